// >>> hw/meot_top.sv
// Two-channel motion event output unit with Wishbone register slave
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
module meot_top
  import meot_pkg::*;
#(
  parameter logic [31:0] POS_LIMIT = POS_LIMIT_D,
  parameter logic [31:0] VEL_LIMIT = VEL_LIMIT_D
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [4:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // Sequence step port
  input  wire logic              seq_valid_i,
  input  wire logic              seq_ch_i,
  input  wire logic [CFG_W-1:0]  seq_cfg_i,
  input  wire logic [31:0]       seq_thr_i,
  // Motion profile state
  input  wire logic              motion_start_i,
  input  wire logic              motion_active_i,
  input  wire logic [31:0]       elapsed_ms_i,
  input  wire logic [31:0]       distance_i,
  input  wire logic [31:0]       speed_i,
  // Lines held by system output functions
  input  wire logic [3:0]        sys_assign_i,
  // Outputs
  output logic      [3:0]        gpo_o,
  output logic                   irq_o
);

  typedef struct packed {
    logic [1:0][CFG_W-1:0] cfg;
    logic [1:0][31:0]      thr;
    logic [1:0]            done;
    logic [3:0]            gpo;
    logic [ST_W-1:0]       status;
    logic [ST_W-1:0]       mask;
    logic [31:0]           rdata;
    logic                  ack;
    logic                  irq;
  } meot_state_t;

  meot_state_t r;
  meot_state_t next_r;

  // Byte-lane merge for a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Range check of a configuration against its threshold
  function automatic logic cfg_ok(input logic [CFG_W-1:0] c, input logic [31:0] t);
    logic ok;
    ok = 1'b1;
    if (c[CFG_EN_BIT]) begin
      unique case (c[CFG_SRC_LSB +: 2])
        SRC_TIME:  ok = (t <= TIME_MAX_MS);
        SRC_DIST:  ok = ($signed(t) <= $signed(POS_LIMIT))
                      && ($signed(t) >= -$signed(POS_LIMIT));
        SRC_SPEED: ok = (t >= SPEED_MIN) && (t <= VEL_LIMIT);
        default:   ok = 1'b0;
      endcase
    end
    return ok;
  endfunction : cfg_ok

  // Threshold reached for the selected quantity
  function automatic logic reached(input logic [1:0] src, input logic [31:0] t);
    logic hit;
    hit = 1'b0;
    unique case (src)
      SRC_TIME:  hit = (elapsed_ms_i >= t);
      SRC_DIST: begin
        // Negative thresholds are reached travelling the other way
        if ($signed(t) < 0) begin
          hit = ($signed(distance_i) <= $signed(t));
        end else begin
          hit = ($signed(distance_i) >= $signed(t));
        end
      end
      SRC_SPEED: hit = (speed_i >= t);
      default:   hit = 1'b0;
    endcase
    return hit;
  endfunction : reached

  logic        req;
  logic        wr;
  logic [31:0] wthr;
  logic [CFG_W-1:0] wcfg;
  logic [ST_W-1:0]  ev;
  logic [1:0]  out_idx;

  always_comb begin
    next_r  = r;
    ev      = '0;
    wthr    = '0;
    wcfg    = '0;
    out_idx = '0;
    // Single-cycle answer; ack drops the cycle after it is given
    req          = cyc_i && stb_i && !r.ack;
    wr           = req && we_i;
    next_r.ack   = req;
    next_r.rdata = '0;

    if (req && !we_i) begin
      unique case (adr_i)
        REG_CH0_CFG: next_r.rdata = 32'(r.cfg[0]);
        REG_CH1_CFG: next_r.rdata = 32'(r.cfg[1]);
        REG_CH0_THR: next_r.rdata = r.thr[0];
        REG_CH1_THR: next_r.rdata = r.thr[1];
        REG_GPO:     next_r.rdata = 32'(r.gpo);
        REG_STATUS:  next_r.rdata = 32'(r.status);
        REG_MASK:    next_r.rdata = 32'(r.mask);
        REG_STATE:   next_r.rdata = {29'h0, motion_active_i, r.done};
        default:     next_r.rdata = '0;
      endcase
    end

    if (wr) begin
      unique case (adr_i)
        REG_CH0_THR: next_r.thr[0] = merge(r.thr[0], dat_i, sel_i);
        REG_CH1_THR: next_r.thr[1] = merge(r.thr[1], dat_i, sel_i);
        REG_GPO: begin
          // Only a host write brings a line back
          wthr       = merge(32'(r.gpo), dat_i, sel_i);
          next_r.gpo = wthr[3:0];
        end
        REG_MASK: begin
          wthr        = merge(32'(r.mask), dat_i, sel_i);
          next_r.mask = wthr[ST_W-1:0];
        end
        default: ;
      endcase
    end

    // Direct configuration: the threshold register must be loaded first
    for (int c = 0; c < 2; c++) begin
      if (wr && sel_i[0] && adr_i == (c == 0 ? REG_CH0_CFG : REG_CH1_CFG)) begin
        wcfg = dat_i[CFG_W-1:0];
        if (!wcfg[CFG_EN_BIT]) begin
          next_r.cfg[c] = CFG_RST;
        end else if (cfg_ok(wcfg, r.thr[c])) begin
          next_r.cfg[c]  = wcfg;
          next_r.done[c] = 1'b0;
        end else begin
          ev[ST_REJ] = 1'b1;
        end
      end
    end

    // Enabling steps that pass the range check load both fields at once and win over a same-cycle bus write; a clear step loads only the config
    if (seq_valid_i) begin
      if (!seq_cfg_i[CFG_EN_BIT]) begin
        next_r.cfg[seq_ch_i] = CFG_RST;
      end else if (cfg_ok(seq_cfg_i, seq_thr_i)) begin
        next_r.cfg[seq_ch_i]  = seq_cfg_i;
        next_r.thr[seq_ch_i]  = seq_thr_i;
        next_r.done[seq_ch_i] = 1'b0;
      end else begin
        ev[ST_REJ] = 1'b1;
      end
    end

    // Each motion start re-arms; configuration itself is kept across motions
    if (motion_start_i) begin
      next_r.done = '0;
    end else if (motion_active_i) begin
      // Both channels checked in parallel; channel 1 applied last on a shared line
      for (int c = 0; c < 2; c++) begin
        if (r.cfg[c][CFG_EN_BIT] && !r.done[c]
            && reached(r.cfg[c][CFG_SRC_LSB +: 2], r.thr[c])) begin
          next_r.done[c] = 1'b1;
          ev[c]          = 1'b1;
          out_idx        = r.cfg[c][CFG_OUT_LSB +: 2];
          if (!sys_assign_i[out_idx]) begin
            next_r.gpo[out_idx] = r.cfg[c][CFG_LVL_BIT];
          end
        end
      end
    end
    // Output is never restored here; end of motion leaves it as driven

    // Sticky status: a new event wins over a same-cycle clear
    if (wr && adr_i == REG_STATUS && sel_i[0]) begin
      next_r.status = r.status & ~dat_i[ST_W-1:0];
    end
    next_r.status = next_r.status | ev;
    next_r.irq    = |(next_r.status & next_r.mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r.cfg    <= {CFG_RST, CFG_RST};
      r.thr    <= {THR_RST, THR_RST};
      r.done   <= '0;
      r.gpo    <= GPO_RST;
      r.status <= ST_RST;
      r.mask   <= ST_RST;
      r.rdata  <= '0;
      r.ack    <= 1'b0;
      r.irq    <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign dat_o = r.rdata;
  assign ack_o = r.ack;
  assign gpo_o = r.gpo;
  assign irq_o = r.irq;

endmodule : meot_top

// >>> hw/meot_pkg.sv
// Constants for the motion event output unit
package meot_pkg;
  // Register byte offsets
  localparam logic [4:0] REG_CH0_CFG = 5'h00;
  localparam logic [4:0] REG_CH1_CFG = 5'h04;
  localparam logic [4:0] REG_CH0_THR = 5'h08;
  localparam logic [4:0] REG_CH1_THR = 5'h0c;
  localparam logic [4:0] REG_GPO     = 5'h10;
  localparam logic [4:0] REG_STATUS  = 5'h14;
  localparam logic [4:0] REG_MASK    = 5'h18;
  localparam logic [4:0] REG_STATE   = 5'h1c;

  // Channel configuration field layout
  localparam int CFG_W       = 6;
  localparam int CFG_EN_BIT  = 0;
  localparam int CFG_OUT_LSB = 1;
  localparam int CFG_LVL_BIT = 3;
  localparam int CFG_SRC_LSB = 4;

  // Trigger sources
  localparam logic [1:0] SRC_TIME  = 2'h0;
  localparam logic [1:0] SRC_DIST  = 2'h1;
  localparam logic [1:0] SRC_SPEED = 2'h2;

  // Status bit positions
  localparam int ST_FIRE0 = 0;
  localparam int ST_FIRE1 = 1;
  localparam int ST_REJ   = 2;
  localparam int ST_W     = 3;

  // Limits: time in milliseconds, speed in thousandths of a unit
  localparam logic [31:0] TIME_MAX_S   = 32'h0000_01f4;
  localparam logic [31:0] MS_PER_S     = 32'h0000_03e8;
  localparam logic [31:0] TIME_MAX_MS  = 32'(TIME_MAX_S * MS_PER_S);
  localparam logic [31:0] SPEED_MIN    = 32'h0000_0001;
  localparam logic [31:0] POS_LIMIT_D  = 32'h0007_a120;
  localparam logic [31:0] VEL_LIMIT_D  = 32'h0012_ebc0;

  // Reset values
  localparam logic [CFG_W-1:0] CFG_RST  = 6'h00;
  localparam logic [31:0]      THR_RST  = 32'h0000_0000;
  localparam logic [3:0]       GPO_RST  = 4'h0;
  localparam logic [ST_W-1:0]  ST_RST   = 3'h0;
endpackage : meot_pkg

// >>> tb/meot_top_sva.sv
// Port assertions for the motion event unit
`timescale 1ns/100ps
module meot_top_sva (
  // Observed ports
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        motion_active_i,
  input wire logic        seq_valid_i,
  input wire logic [3:0]  sys_assign_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  input wire logic [3:0]  gpo_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_quiet;
    (!cyc_i && !motion_active_i)[*2];
  endsequence
  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  chk_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  chk_gpo_hold: assert property (s_quiet |=> $stable(gpo_o))
    else $error("output moved while idle");
  chk_sys_block: assert property ((!cyc_i && sys_assign_i[3])[*2] |=> $stable(gpo_o[3]))
    else $error("owned line changed");
  chk_irq_quiet: assert property ((!cyc_i && !motion_active_i && !seq_valid_i && !irq_o)[*3]
    |=> !irq_o)
    else $error("irq without cause");
  chk_gpo_cause: assert property ($changed(gpo_o) |->
    $past(cyc_i) || $past(motion_active_i) || $past(motion_active_i, 2))
    else $error("output changed without cause");
endmodule : meot_top_sva
bind meot_top meot_top_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .motion_active_i(motion_active_i), .seq_valid_i(seq_valid_i), .sys_assign_i(sys_assign_i),
  .ack_o(ack_o), .dat_o(dat_o), .gpo_o(gpo_o), .irq_o(irq_o));

// >>> tb/meot_seq_host.sv
// Sequence step source standing in for a stored program
`timescale 1ns/100ps
module meot_seq_host
  import meot_pkg::*;
(
  // Clock
  input  wire logic             clk_i,
  // Step port
  output logic                  seq_valid_o = 1'b0,
  output logic                  seq_ch_o = 1'b0,
  output logic [CFG_W-1:0]      seq_cfg_o = '0,
  output logic [31:0]           seq_thr_o = '0
);
  // Zero config is the clear form
  task automatic step(input logic c, input logic [CFG_W-1:0] f, input logic [31:0] t);
    @(posedge clk_i);
    seq_valid_o <= 1'b1;
    seq_ch_o <= c;
    seq_cfg_o <= f;
    seq_thr_o <= t;
    @(posedge clk_i);
    seq_valid_o <= 1'b0;
    // Stale fields scrambled so nothing leans on them
    seq_cfg_o <= ~f;
    seq_thr_o <= ~t;
  endtask : step
endmodule : meot_seq_host

// >>> tb/meot_top_tb.sv
// Self-checking bench for the motion event unit
`timescale 1ns/100ps
module meot_top_tb
  import meot_pkg::*;
;
  logic              clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [4:0]        adr_i = '0;
  logic [31:0]       dat_i = '0, dat_o, rd, elapsed_ms_i = '0, distance_i = '0, speed_i = '0;
  logic              ack_o, irq_o, seq_valid_i, seq_ch_i, motion_start_i = 1'b0;
  logic              motion_active_i = 1'b0;
  logic [CFG_W-1:0]  seq_cfg_i;
  logic [31:0]       seq_thr_i;
  logic [3:0]        sys_assign_i = 4'h0, gpo_o;
  int                fail_count = 0, checks = 0, cyc_cnt = 0;
  always #4 clk_i = ~clk_i;
  meot_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .seq_valid_i(seq_valid_i), .seq_ch_i(seq_ch_i), .seq_cfg_i(seq_cfg_i),
    .seq_thr_i(seq_thr_i), .motion_start_i(motion_start_i), .motion_active_i(motion_active_i),
    .elapsed_ms_i(elapsed_ms_i), .distance_i(distance_i), .speed_i(speed_i),
    .sys_assign_i(sys_assign_i), .gpo_o(gpo_o), .irq_o(irq_o));
  meot_seq_host u_seq (.clk_i(clk_i), .seq_valid_o(seq_valid_i), .seq_ch_o(seq_ch_i),
    .seq_cfg_o(seq_cfg_i), .seq_thr_o(seq_thr_i));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 40);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 40) fail_count++;
  endtask : wb
  // Travel runs negative so the distance test sees a signed threshold
  task automatic motion(input int n);
    @(posedge clk_i);
    motion_start_i <= 1'b1;
    motion_active_i <= 1'b1;
    elapsed_ms_i <= '0;
    distance_i <= '0;
    speed_i <= '0;
    @(posedge clk_i);
    motion_start_i <= 1'b0;
    for (int i = 1; i <= n; i++) begin
      @(posedge clk_i);
      elapsed_ms_i <= 32'(i);
      distance_i <= 32'(-i);
      speed_i <= 32'(i);
    end
    @(posedge clk_i);
    motion_active_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : motion
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_CH1_CFG, 32'h0);
    chk("ch1_cfg", rd, 32'h0);
    wb(1'b1, REG_GPO, 32'h0);
    wb(1'b1, REG_MASK, 32'h7);
    wb(1'b1, REG_CH0_THR, 32'h5);
    wb(1'b1, REG_CH0_CFG, 32'h0b);
    u_seq.step(1'b1, 6'h29, 32'ha);
    motion(12);
    chk("gpo", {28'h0, gpo_o}, 32'h3);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("status", rd, 32'h3);
    chk("irq", {31'h0, irq_o}, 32'h1);
    $display("test 1 done");
    wb(1'b1, REG_STATUS, 32'h7);
    wb(1'b1, REG_GPO, 32'h0);
    chk("irq", {31'h0, irq_o}, 32'h0);
    sys_assign_i <= 4'h8;
    wb(1'b1, REG_CH0_THR, 32'hffff_fffb);
    wb(1'b1, REG_CH0_CFG, 32'h1f);
    motion(12);
    chk("gpo", {28'h0, gpo_o}, 32'h1);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("status", rd, 32'h3);
    $display("test 2 done");
    u_seq.step(1'b1, 6'h00, 32'h0);
    wb(1'b0, REG_CH1_CFG, 32'h0);
    chk("ch1_cfg", rd, 32'h0);
    chk("gpo", {28'h0, gpo_o}, 32'h1);
    sys_assign_i <= 4'h0;
    motion(8);
    chk("gpo", {28'h0, gpo_o}, 32'h9);
    $display("test 3 done");
    end_of_test();
  end
endmodule : meot_top_tb
